// [rtl/ptc_pkg.sv]
`default_nettype none
package ptc_pkg;
  // Register addresses on the host register port
  localparam logic [7:0] ADDR_ADDEND = 8'h80;
  localparam logic [7:0] ADDR_CMP = 8'h81;
  localparam logic [7:0] ADDR_SEC = 8'h82;
  localparam logic [7:0] ADDR_NS = 8'h83;
  localparam logic [7:0] ADDR_CFG = 8'h84;
  localparam logic [7:0] ADDR_HIGH = 8'h85;
  localparam logic [7:0] ADDR_LOW = 8'h86;
  localparam logic [7:0] ADDR_START = 8'h88;
  // Configuration bit positions
  localparam int CFG_EN_BIT = 0;
  localparam int CFG_CLR_BIT = 1;
  localparam int CFG_IDLE_BIT = 2;
  localparam int CFG_STOP_BIT = 3;
  localparam int CFG_FREE_BIT = 4;
  // Values after reset
  localparam logic [31:0] ADDEND_RST = 32'h85555555;
  localparam logic [31:0] CMP_RST = 32'h3b9aca00;
  localparam logic [31:0] COUNT_RST = 32'h00000000;
  // Nanosecond step and smallest legal start time, in nanoseconds, and the seconds and free running step
  localparam logic [31:0] NS_STEP = 32'h00000010;
  localparam logic [31:0] START_MIN = 32'h00000010;
  localparam logic [31:0] FREE_STEP = 32'h00000001;
endpackage
`default_nettype wire

// [rtl/ptc_time_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface ptc_time_if;
  logic en;
  logic tick;
  logic [31:0] ns;
  logic [31:0] sec;
  logic [31:0] free;
  modport src (output en, tick, ns, sec, free);
  modport snk (input en, tick, ns, sec, free);
endinterface
`default_nettype wire

// [rtl/ptc_periodic_output.sv]
`timescale 1ns/1ps
`default_nettype none
module ptc_periodic_output import ptc_pkg::*; (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Time base
  ptc_time_if.snk tb,
  // Control
  input wire logic i_start,
  input wire logic i_stop,
  input wire logic [31:0] i_start_time,
  input wire logic [31:0] i_high_period,
  input wire logic [31:0] i_low_period,
  input wire logic i_idle_level,
  input wire logic i_led_pin_sel,
  input wire logic i_led_polarity,
  // Output
  output logic o_level,
  output logic o_busy
);
  typedef enum logic [1:0] {pg_idle, pg_armed, pg_run} pg_state_type;
  pg_state_type state_q, state_d;
  logic phase_q;
  logic [31:0] cnt_q;
  logic [31:0] cnt_next;
  logic [31:0] period;
  logic idle_eff;

  assign idle_eff = i_idle_level ^ (i_led_pin_sel & i_led_polarity);
  assign cnt_next = cnt_q + NS_STEP;
  assign period = phase_q ? i_high_period : i_low_period;

  always_comb begin
    state_d = state_q;
    case (state_q)
      pg_idle: if (i_start) state_d = pg_armed;
      pg_armed: if (tb.en && tb.ns == i_start_time) state_d = pg_run;
      pg_run: if (i_start) state_d = pg_armed;
      default: state_d = pg_idle;
    endcase
    if (i_stop) begin
      state_d = pg_idle;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_q <= pg_idle;
      o_busy <= 1'b0;
    end else begin
      state_q <= state_d;
      o_busy <= (state_d != pg_idle);
    end
  end

  // High phase first, each phase timed in 16 ns steps
  always_ff @(posedge i_clk) begin
    if (i_rst || state_q != pg_run) begin
      phase_q <= 1'b1;
      cnt_q <= COUNT_RST;
    end else if (tb.tick) begin
      if (cnt_next >= period) begin
        phase_q <= ~phase_q;
        cnt_q <= COUNT_RST;
      end else begin
        cnt_q <= cnt_next;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_level <= 1'b0;
    end else begin
      o_level <= (state_d == pg_run && state_q == pg_run) ? phase_q : idle_eff;
    end
  end

  chk_stop_idle: assert property (@(posedge i_clk) disable iff (i_rst)
    i_stop |=> !o_busy && o_level == $past(idle_eff))
    else $error("periodic output not idle after stop");
  chk_start_arms: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_start && !i_stop) |=> o_busy)
    else $error("periodic output did not arm on start");
  chk_idle_holds: assert property (@(posedge i_clk) disable iff (i_rst)
    (state_q == pg_idle && !i_start) |=> o_level == $past(idle_eff))
    else $error("periodic output left idle without a start");
endmodule
`default_nettype wire

// [rtl/ptc_stamp_capture.sv]
`timescale 1ns/1ps
`default_nettype none
module ptc_stamp_capture import ptc_pkg::*; (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Time base
  ptc_time_if.snk tb,
  // Frame event and format
  input wire logic i_frame,
  input wire logic i_full_stamp_select,
  input wire logic i_free_select,
  // Captured stamp
  output logic o_valid,
  output logic o_wide,
  output logic o_free,
  output logic [63:0] o_stamp
);
  logic take;
  logic [63:0] stamp_d;

  assign take = i_frame && tb.en;

  always_comb begin
    if (i_full_stamp_select) begin
      stamp_d = {tb.sec, tb.ns};
    end else if (i_free_select) begin
      stamp_d = {32'h00000000, tb.free};
    end else begin
      stamp_d = {32'h00000000, tb.sec[1:0], tb.ns[29:0]};
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_valid <= 1'b0;
      o_wide <= 1'b0;
      o_free <= 1'b0;
      o_stamp <= 64'h0000000000000000;
    end else begin
      o_valid <= take;
      if (take) begin
        o_wide <= i_full_stamp_select;
        o_free <= !i_full_stamp_select && i_free_select;
        o_stamp <= stamp_d;
      end
    end
  end

  chk_stamp_format: assert property (@(posedge i_clk) disable iff (i_rst)
    (take && !i_full_stamp_select && i_free_select)
      |=> o_valid && o_free && o_stamp == {32'h00000000, $past(tb.free)})
    else $error("free running stamp wrong");
  chk_stamp_wide: assert property (@(posedge i_clk) disable iff (i_rst)
    (take && i_full_stamp_select) |=> o_wide && !o_free
      && o_stamp == {$past(tb.sec), $past(tb.ns)})
    else $error("wide stamp wrong");
  chk_stamp_gated: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_frame && !tb.en) |=> !o_valid)
    else $error("stamp taken while counters disabled");
endmodule
`default_nettype wire

// [rtl/precision_time_counter.sv]
`timescale 1ns/1ps
`default_nettype none
module precision_time_counter import ptc_pkg::*; (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Register port
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  output logic [31:0] o_reg_rdata,
  output logic o_reg_rvalid,
  // Received frames
  input wire logic i_frame_rx,
  input wire logic i_full_stamp_select,
  output logic o_stamp_valid,
  output logic o_stamp_wide,
  output logic o_stamp_free,
  output logic [63:0] o_stamp,
  // Periodic output
  input wire logic i_led_pin_sel,
  input wire logic i_led_polarity,
  output logic o_periodic_output,
  output logic o_periodic_busy
);
  ////////////////////////////////////////////////////////////////////////////
  // Write decode
  logic wr_addend;
  logic wr_cmp;
  logic wr_sec;
  logic wr_ns;
  logic wr_cfg;
  logic wr_high;
  logic wr_low;
  logic wr_start;
  logic counter_clear;
  logic periodic_output_stop;
  logic start_go;

  assign wr_addend = i_reg_wr && i_reg_addr == ADDR_ADDEND;
  assign wr_cmp = i_reg_wr && i_reg_addr == ADDR_CMP;
  assign wr_sec = i_reg_wr && i_reg_addr == ADDR_SEC;
  assign wr_ns = i_reg_wr && i_reg_addr == ADDR_NS;
  assign wr_cfg = i_reg_wr && i_reg_addr == ADDR_CFG;
  assign wr_high = i_reg_wr && i_reg_addr == ADDR_HIGH;
  assign wr_low = i_reg_wr && i_reg_addr == ADDR_LOW;
  assign wr_start = i_reg_wr && i_reg_addr == ADDR_START;
  // Write-only strobes, never stored, so the clear and stop bits read back as zero
  assign counter_clear = wr_cfg && i_reg_wdata[CFG_CLR_BIT];
  assign periodic_output_stop = wr_cfg && i_reg_wdata[CFG_STOP_BIT];
  assign start_go = wr_start && i_reg_wdata >= START_MIN;

  ////////////////////////////////////////////////////////////////////////////
  // Host registers
  logic [31:0] accumulator_addend_q;
  logic [31:0] one_second_compare_q;
  logic [31:0] periodic_high_period_q;
  logic [31:0] periodic_low_period_q;
  logic [31:0] start_time_value_q;
  logic counter_enable_q;
  logic freerun_capture_select_q;
  logic periodic_output_idle_level_q;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      accumulator_addend_q <= ADDEND_RST;
    end else if (wr_addend) begin
      accumulator_addend_q <= i_reg_wdata;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      one_second_compare_q <= CMP_RST;
    end else if (wr_cmp) begin
      one_second_compare_q <= i_reg_wdata;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      periodic_high_period_q <= COUNT_RST;
      periodic_low_period_q <= COUNT_RST;
      start_time_value_q <= COUNT_RST;
    end else begin
      if (wr_high) begin
        periodic_high_period_q <= i_reg_wdata;
      end
      if (wr_low) begin
        periodic_low_period_q <= i_reg_wdata;
      end
      if (wr_start) begin
        start_time_value_q <= i_reg_wdata;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      counter_enable_q <= 1'b0;
      freerun_capture_select_q <= 1'b0;
      periodic_output_idle_level_q <= 1'b0;
    end else if (wr_cfg) begin
      counter_enable_q <= i_reg_wdata[CFG_EN_BIT];
      freerun_capture_select_q <= i_reg_wdata[CFG_FREE_BIT];
      if (!o_periodic_busy) begin
        periodic_output_idle_level_q <= i_reg_wdata[CFG_IDLE_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Time base: accumulator, nanoseconds, seconds, free running
  logic [31:0] acc_q;
  logic [31:0] ns_q;
  logic [31:0] sec_q;
  logic [31:0] free_q;
  logic [32:0] acc_sum;
  logic [31:0] ns_next;
  logic carry;
  logic wrap;

  assign acc_sum = {1'b0, acc_q} + {1'b0, accumulator_addend_q};
  assign carry = counter_enable_q && acc_sum[32];
  assign ns_next = ns_q + NS_STEP;
  assign wrap = carry && ns_next >= one_second_compare_q;

  always_ff @(posedge i_clk) begin
    if (i_rst || counter_clear) begin
      acc_q <= COUNT_RST;
    end else if (counter_enable_q) begin
      acc_q <= acc_sum[31:0];
    end
  end

  // Host load wins over counting in the same cycle
  always_ff @(posedge i_clk) begin
    if (i_rst || counter_clear) begin
      ns_q <= COUNT_RST;
    end else if (wr_ns) begin
      ns_q <= i_reg_wdata;
    end else if (wrap) begin
      ns_q <= COUNT_RST;
    end else if (carry) begin
      ns_q <= ns_next;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst || counter_clear) begin
      sec_q <= COUNT_RST;
    end else if (wr_sec) begin
      sec_q <= i_reg_wdata;
    end else if (wrap) begin
      sec_q <= sec_q + FREE_STEP;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst || counter_clear) begin
      free_q <= COUNT_RST;
    end else if (counter_enable_q) begin
      free_q <= free_q + FREE_STEP;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Time bus to the stamp and output blocks
  ptc_time_if tb ();

  assign tb.en = counter_enable_q;
  assign tb.tick = carry;
  assign tb.ns = ns_q;
  assign tb.sec = sec_q;
  assign tb.free = free_q;

  ptc_stamp_capture u_capture (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .tb(tb.snk),
    .i_frame(i_frame_rx),
    .i_full_stamp_select(i_full_stamp_select),
    .i_free_select(freerun_capture_select_q),
    .o_valid(o_stamp_valid),
    .o_wide(o_stamp_wide),
    .o_free(o_stamp_free),
    .o_stamp(o_stamp)
  );

  ptc_periodic_output u_periodic (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .tb(tb.snk),
    .i_start(start_go),
    .i_stop(periodic_output_stop),
    .i_start_time(start_time_value_q),
    .i_high_period(periodic_high_period_q),
    .i_low_period(periodic_low_period_q),
    .i_idle_level(periodic_output_idle_level_q),
    .i_led_pin_sel(i_led_pin_sel),
    .i_led_polarity(i_led_polarity),
    .o_level(o_periodic_output),
    .o_busy(o_periodic_busy)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Read back, one cycle after the read strobe
  logic [31:0] rdata_d;

  always_comb begin
    case (i_reg_addr)
      ADDR_ADDEND: rdata_d = accumulator_addend_q;
      ADDR_CMP: rdata_d = one_second_compare_q;
      ADDR_SEC: rdata_d = sec_q;
      ADDR_NS: rdata_d = ns_q;
      ADDR_CFG: begin
        rdata_d = 32'h00000000;
        rdata_d[CFG_EN_BIT] = counter_enable_q;
        rdata_d[CFG_IDLE_BIT] = periodic_output_idle_level_q;
        rdata_d[CFG_FREE_BIT] = freerun_capture_select_q;
      end
      ADDR_HIGH: rdata_d = periodic_high_period_q;
      ADDR_LOW: rdata_d = periodic_low_period_q;
      ADDR_START: rdata_d = start_time_value_q;
      default: rdata_d = 32'h00000000;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_reg_rdata <= 32'h00000000;
      o_reg_rvalid <= 1'b0;
    end else begin
      o_reg_rvalid <= i_reg_rd;
      if (i_reg_rd) begin
        o_reg_rdata <= rdata_d;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  chk_addend_reset: assert property (@(posedge i_clk)
    i_rst |=> accumulator_addend_q == ADDEND_RST && one_second_compare_q == CMP_RST)
    else $error("addend or compare not at reset value");

  chk_addend_write: assert property (@(posedge i_clk) disable iff (i_rst)
    wr_addend |=> accumulator_addend_q == $past(i_reg_wdata))
    else $error("addend register did not take write");

  chk_addend_hold: assert property (@(posedge i_clk) disable iff (i_rst)
    !wr_addend |=> $stable(accumulator_addend_q))
    else $error("addend register changed without a write");

  chk_read_latency: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_reg_rd && i_reg_addr == ADDR_ADDEND)
      |=> o_reg_rvalid && o_reg_rdata == $past(accumulator_addend_q))
    else $error("addend read back wrong or late");

  chk_compare_write: assert property (@(posedge i_clk) disable iff (i_rst)
    wr_cmp |=> one_second_compare_q == $past(i_reg_wdata))
    else $error("compare register did not take write");

  chk_compare_hold: assert property (@(posedge i_clk) disable iff (i_rst)
    !wr_cmp |=> $stable(one_second_compare_q))
    else $error("compare register changed without a write");

  chk_seconds_load: assert property (@(posedge i_clk) disable iff (i_rst)
    (wr_sec && !counter_clear) |=> sec_q == $past(i_reg_wdata))
    else $error("seconds counter did not load");

  chk_seconds_hold: assert property (@(posedge i_clk) disable iff (i_rst)
    (!wrap && !wr_sec && !counter_clear) |=> $stable(sec_q))
    else $error("seconds moved without a rollover");

  chk_ns_step: assert property (@(posedge i_clk) disable iff (i_rst)
    (carry && !wrap && !wr_ns && !counter_clear) |=> ns_q == $past(ns_q) + NS_STEP)
    else $error("nanoseconds did not step by sixteen");

  chk_ns_hold: assert property (@(posedge i_clk) disable iff (i_rst)
    (!carry && !wr_ns && !counter_clear) |=> $stable(ns_q))
    else $error("nanoseconds moved without a carry");

  chk_second_wrap: assert property (@(posedge i_clk) disable iff (i_rst)
    (wrap && !wr_ns && !wr_sec && !counter_clear)
      |=> ns_q == COUNT_RST && sec_q == $past(sec_q) + FREE_STEP)
    else $error("second rollover wrong");

  chk_clear_all: assert property (@(posedge i_clk) disable iff (i_rst)
    counter_clear |=> acc_q == COUNT_RST && ns_q == COUNT_RST
      && sec_q == COUNT_RST && free_q == COUNT_RST)
    else $error("counter clear missed a counter");

  chk_freeze: assert property (@(posedge i_clk) disable iff (i_rst)
    (!counter_enable_q && !i_reg_wr) |=> $stable(acc_q) && $stable(ns_q)
      && $stable(sec_q) && $stable(free_q))
    else $error("counters moved while disabled");

  chk_acc_add: assert property (@(posedge i_clk) disable iff (i_rst)
    (counter_enable_q && !counter_clear)
      |=> acc_q == $past(acc_q) + $past(accumulator_addend_q))
    else $error("accumulator did not add addend");

  chk_free_run: assert property (@(posedge i_clk) disable iff (i_rst)
    (counter_enable_q && !counter_clear) |=> free_q == $past(free_q) + FREE_STEP)
    else $error("free running counter did not advance");

  chk_idle_ignored: assert property (@(posedge i_clk) disable iff (i_rst)
    (wr_cfg && o_periodic_busy) |=> $stable(periodic_output_idle_level_q))
    else $error("idle level changed while output enabled");

  chk_idle_drive: assert property (@(posedge i_clk) disable iff (i_rst)
    (wr_cfg && i_reg_wdata[CFG_IDLE_BIT] && !o_periodic_busy && !start_go
      && !i_led_pin_sel) |=> ##1 o_periodic_output)
    else $error("idle level write did not reach output");

  chk_short_start: assert property (@(posedge i_clk) disable iff (i_rst)
    (wr_start && i_reg_wdata < START_MIN && !o_periodic_busy) |=> !o_periodic_busy)
    else $error("start below minimum armed the output");

  chk_stop_selfclear: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_reg_rd && i_reg_addr == ADDR_CFG)
      |=> !o_reg_rdata[CFG_STOP_BIT] && !o_reg_rdata[CFG_CLR_BIT])
    else $error("write-only config bits read back set");
endmodule
`default_nettype wire

// [bench/precision_time_counter_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module precision_time_counter_bench import ptc_pkg::*;;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_reg_wr = 1'b0;
  logic i_reg_rd = 1'b0;
  logic [7:0] i_reg_addr = 8'h00;
  logic [31:0] i_reg_wdata = 32'h00000000;
  logic i_frame_rx = 1'b0;
  logic i_full_stamp_select = 1'b0;
  logic i_led_pin_sel = 1'b0;
  logic i_led_polarity = 1'b0;
  logic [31:0] o_reg_rdata;
  logic o_reg_rvalid;
  logic o_stamp_valid;
  logic o_stamp_wide;
  logic o_stamp_free;
  logic [63:0] o_stamp;
  logic o_periodic_output;
  logic o_periodic_busy;
  int n_fail = 0;
  int tests_run = 0;
  int cycles = 0;
  typedef struct {logic [7:0] a; logic [31:0] w; logic [31:0] rst; logic [31:0] rb;} row_type;
  row_type rows[10] = '{
    '{ADDR_ADDEND, 32'h12345670, ADDEND_RST, 32'h12345670},
    '{ADDR_CMP, 32'h00000100, CMP_RST, 32'h00000100},
    '{ADDR_SEC, 32'ha5a5a5a5, COUNT_RST, 32'ha5a5a5a5},
    '{ADDR_NS, 32'h00000ff0, COUNT_RST, 32'h00000ff0},
    '{ADDR_CFG, 32'hfffffff0, 32'h00000000, 32'h00000010},
    '{ADDR_HIGH, 32'h00000020, 32'h00000000, 32'h00000020},
    '{ADDR_LOW, 32'h00000030, 32'h00000000, 32'h00000030},
    '{ADDR_START, 32'h0000000f, 32'h00000000, 32'h0000000f},
    '{8'h87, 32'hffffffff, 32'h00000000, 32'h00000000},
    '{8'h7f, 32'hffffffff, 32'h00000000, 32'h00000000}};
  logic [31:0] d;
  logic [31:0] d2;

  precision_time_counter precision_time_counter_i (
    .i_clk(i_clk), .i_rst(i_rst),
    .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid),
    .i_frame_rx(i_frame_rx), .i_full_stamp_select(i_full_stamp_select),
    .o_stamp_valid(o_stamp_valid), .o_stamp_wide(o_stamp_wide),
    .o_stamp_free(o_stamp_free), .o_stamp(o_stamp),
    .i_led_pin_sel(i_led_pin_sel), .i_led_polarity(i_led_polarity),
    .o_periodic_output(o_periodic_output), .o_periodic_busy(o_periodic_busy)
  );

  always #25 i_clk = ~i_clk;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    if (n_fail == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      n_fail++;
      close_out();
    end
  end

  task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Bus cycles start and end at a falling edge
  task automatic reg_write(input logic [7:0] a, input logic [31:0] w);
    i_reg_wr = 1'b1;
    i_reg_addr = a;
    i_reg_wdata = w;
    @(negedge i_clk);
    i_reg_wr = 1'b0;
    @(negedge i_clk);
  endtask

  task automatic reg_read(input logic [7:0] a, output logic [31:0] r);
    i_reg_rd = 1'b1;
    i_reg_addr = a;
    @(negedge i_clk);
    i_reg_rd = 1'b0;
    check("read valid", o_reg_rvalid, 1);
    r = o_reg_rdata;
    @(negedge i_clk);
  endtask

  task automatic frame(input logic exp_valid);
    i_frame_rx = 1'b1;
    @(negedge i_clk);
    i_frame_rx = 1'b0;
    check("stamp valid", o_stamp_valid, exp_valid);
    @(negedge i_clk);
  endtask

  task automatic wait_out(input logic v, input int lim);
    int k;
    for (k = 0; k < lim && o_periodic_output !== v; k++) begin
      @(negedge i_clk);
    end
    check("periodic level", o_periodic_output, v);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(negedge i_clk);
    i_rst = 1'b0;
    @(negedge i_clk);
    check("output after reset", {o_periodic_output, o_periodic_busy}, 0);
    foreach (rows[i]) begin
      reg_read(rows[i].a, d);
      check("reset value", d, rows[i].rst);
      reg_write(rows[i].a, rows[i].w);
      reg_read(rows[i].a, d);
      check("readback", d, rows[i].rb);
    end
    check("short start busy", o_periodic_busy, 0);
    // Stamp formats with seconds and nanoseconds parked
    reg_write(ADDR_CFG, 32'h00000000);
    frame(1'b0);
    reg_write(ADDR_ADDEND, 32'h00000000);
    reg_write(ADDR_CFG, 32'h00000001);
    frame(1'b1);
    check("standard stamp", o_stamp, 64'h0000000040000ff0);
    check("standard kind", {o_stamp_wide, o_stamp_free}, 2'b00);
    i_full_stamp_select = 1'b1;
    reg_write(ADDR_CFG, 32'h00000011);
    frame(1'b1);
    check("full stamp", o_stamp, 64'ha5a5a5a500000ff0);
    check("full kind", o_stamp_wide, 1);
    i_full_stamp_select = 1'b0;
    reg_write(ADDR_CFG, 32'h00000013);
    reg_read(ADDR_CFG, d);
    check("clear self clears", d, 32'h00000011);
    frame(1'b1);
    check("free kind", o_stamp_free, 1);
    check("free small", o_stamp < 64'h0000000000000014, 1);
    reg_read(ADDR_SEC, d);
    check("sec cleared", d, 0);
    reg_read(ADDR_NS, d);
    check("ns cleared", d, 0);
    // Counting, wrap at compare 0x100 and freeze
    reg_write(ADDR_CFG, 32'h00000002);
    reg_write(ADDR_ADDEND, 32'h80000000);
    reg_write(ADDR_CFG, 32'h00000001);
    repeat (40) @(negedge i_clk);
    reg_write(ADDR_CFG, 32'h00000000);
    reg_read(ADDR_SEC, d);
    check("sec after wrap", d, 1);
    reg_read(ADDR_NS, d);
    check("ns step", d[3:0], 0);
    check("ns range", d >= 32 && d <= 160, 1);
    repeat (10) @(negedge i_clk);
    reg_read(ADDR_NS, d2);
    check("ns frozen", d2, d);
    // Periodic output
    reg_write(ADDR_CFG, 32'h00000002);
    reg_write(ADDR_ADDEND, 32'hffffffff);
    reg_write(ADDR_CFG, 32'h00000004);
    check("idle high", o_periodic_output, 1);
    i_led_pin_sel = 1'b1;
    i_led_polarity = 1'b1;
    @(negedge i_clk);
    @(negedge i_clk);
    check("led idle", o_periodic_output, 0);
    i_led_pin_sel = 1'b0;
    i_led_polarity = 1'b0;
    reg_write(ADDR_CFG, 32'h00000000);
    check("idle low", o_periodic_output, 0);
    reg_write(ADDR_HIGH, 32'h00000020);
    reg_write(ADDR_LOW, 32'h00000020);
    reg_write(ADDR_START, 32'h00000010);
    check("busy after start", o_periodic_busy, 1);
    reg_write(ADDR_CFG, 32'h00000004);
    reg_read(ADDR_CFG, d);
    check("idle ignored", d, 0);
    check("idle ignored level", o_periodic_output, 0);
    reg_write(ADDR_CFG, 32'h00000001);
    wait_out(1'b1, 60);
    wait_out(1'b0, 60);
    wait_out(1'b1, 60);
    reg_write(ADDR_CFG, 32'h00000009);
    check("stop busy", o_periodic_busy, 0);
    check("stop level", o_periodic_output, 0);
    reg_read(ADDR_CFG, d);
    check("stop self clears", d, 32'h00000001);
    repeat (40) begin
      @(negedge i_clk);
      check("stays idle", o_periodic_output, 0);
    end
    reg_write(ADDR_START, 32'h00000008);
    check("short start ignored", o_periodic_busy, 0);
    reg_read(ADDR_START, d);
    check("short start stored", d, 32'h00000008);
    reg_write(ADDR_START, 32'h00000010);
    check("restart busy", o_periodic_busy, 1);
    wait_out(1'b1, 400);
    // Reset in mid-run while the output toggles
    i_rst = 1'b1;
    repeat (2) @(negedge i_clk);
    i_rst = 1'b0;
    check("busy after reset", o_periodic_busy, 0);
    check("level after reset", o_periodic_output, 0);
    @(negedge i_clk);
    reg_read(ADDR_ADDEND, d);
    check("addend after reset", d, ADDEND_RST);
    reg_read(ADDR_SEC, d);
    check("sec after reset", d, COUNT_RST);
    close_out();
  end
endmodule
`default_nettype wire
